// *** design/sapf_port.sv ***
`timescale 1ns/1ns
module sapf_port
  import sapf_pkg::*;
(
  // System clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Bit clock from the codec
  input  wire logic        i_link_bclk,
  // Configuration
  input  wire sapf_cfg_t   i_cfg,
  // Transmit buffer writes
  input  wire logic        i_tx_wr,
  input  wire logic [1:0]  i_tx_idx,
  input  wire logic [15:0] i_tx_data,
  // Done flag clear
  input  wire logic        i_done_clr,
  // Serial pins
  input  wire logic        i_serial_in_pin,
  output logic             o_frame_sync_pin,
  output logic             o_serial_out_pin,
  output logic             o_serial_out_oe,
  // Status
  output logic [63:0]      o_rx_words,
  output logic             o_done_flag,
  output logic [4:0]       o_slot_status,
  output logic             o_fs_level
);

  sapf_lnk_t   lq;         // Link state
  sapf_lnk_t   ln;         // Link next state
  sapf_sys_t   sq;         // System state
  sapf_sys_t   sn;         // System next state
  logic [1:0]  lrst_q;     // Link reset release sync
  logic        lrst_b;     // Link domain reset
  logic        sin_fall_q; // Input sampled on falling edge
  sapf_cfg_t   cf;         // Synchronised config
  logic        i2s;        // I2S mode
  logic        ac;         // Either AC-Link mode
  logic [3:0]  wsz_e;      // Effective word size
  logic [3:0]  fl_e;       // Effective frame length
  logic [4:0]  wbits;      // Bits per word
  logic [8:0]  half;       // Half frame or frame bits
  logic [9:0]  frame;      // Frame length in bits
  logic [9:0]  off;        // Data offset from sync edge
  logic [4:0]  wl;         // Slot length in bits
  logic [4:0]  wdata;      // Data bits in slot
  logic [3:0]  idx;        // Slot enable index
  logic [15:0] mask;       // Usable slot enables
  logic        tx_on;      // Current slot transmits
  logic        rx_on;      // Current slot receives
  logic        fs_lvl;     // Frame sync for this bit
  logic [3:0]  bidx;       // Word bit for this bit time
  logic        wend;       // Last bit of slot
  logic        ev;         // Group done seen in system domain

  // Reset release for the link domain; assert is immediate
  always_ff @(posedge i_link_bclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_b = lrst_q[1];

  // Codec input caught on the falling edge, half a bit after it changes
  always_ff @(negedge i_link_bclk or negedge lrst_b) begin
    if (!lrst_b) begin
      sin_fall_q <= 1'b0;
    end else begin
      sin_fall_q <= i_serial_in_pin;
    end
  end

  // Frame geometry from the synchronised config
  always_comb begin
    cf    = lq.cfg_s2;
    i2s   = (cf.fs_mode == MODE_I2S);
    ac    = cf.fs_mode[1];
    // AC20 ignores both size fields
    wsz_e = (cf.fs_mode == MODE_AC20) ? AC20_FORCE : cf.word_size;
    fl_e  = (cf.fs_mode == MODE_AC20) ? AC20_FORCE : cf.frame_len;
    wbits = {1'b0, wsz_e} + 5'h1;
    half  = 9'(({5'h0, fl_e} + 9'h1) * {4'h0, wbits});
    if (ac) begin
      frame = AC_FRAME;
    end else if (i2s) begin
      frame = {half, 1'b0};
    end else begin
      frame = {1'b0, half};
    end
    // Sync level for the bit now being framed
    if (ac) begin
      fs_lvl = (lq.fcnt < AC_FS_HIGH);
    end else if (i2s) begin
      fs_lvl = (lq.fcnt >= {1'b0, half});
    end else begin
      fs_lvl = (lq.fcnt == 10'h0);
    end
    // AC-Link data always trails the sync edge by one bit
    off   = (ac || !cf.justify) ? 10'h1 : 10'h0;
    if (cf.fs_mode == MODE_AC16) begin
      // Tag slot is short, data slots carry 20 bits
      wl    = (lq.slot == 5'h0) ? AC_TAG_BITS : AC_SLOT_BITS;
      wdata = AC16_DATA;
      mask  = AC16_MASK;
    end else begin
      wl    = wbits;
      wdata = wbits;
      mask  = ALL_MASK;
    end
    // I2S enables repeat in each half frame
    idx   = i2s ? lq.hslot : lq.slot[3:0];
    tx_on = cf.tx_slot_en[idx] & mask[idx];
    rx_on = cf.rx_slot_en[idx] & mask[idx];
    bidx  = 4'(wdata - 5'h1 - lq.bitw);
    wend  = (lq.bitw == wl - 5'h1);
  end

  // Link next state
  always_comb begin
    ln        = lq;
    ln.cfg_s1 = i_cfg;
    ln.cfg_s2 = lq.cfg_s1;
    if (!cf.en) begin
      // Stopped: counters parked, sync low
      ln.fcnt    = 10'h0;
      ln.bitw    = 5'h0;
      ln.slot    = 5'h0;
      ln.hslot   = 4'h0;
      ln.widx    = 2'h0;
      ln.run     = 1'b0;
      ln.pend    = 1'b0;
      ln.rx_take = 1'b0;
      ln.fs_q    = 1'b0;
      ln.sout_q  = 1'b0;
      ln.soe_q   = !cf.idle_tri;
    end else begin
      // Store the bit sampled for the previous bit time
      if (lq.rx_take) begin
        ln.rx_grp[{lq.rx_widx, lq.rx_bit}] = sin_fall_q;
      end
      // Group hand-off waits one cycle for the last sample
      if (lq.pend) begin
        ln.rx_hold  = ln.rx_grp;
        ln.done_tgl = !lq.done_tgl;
        ln.pend     = 1'b0;
      end
      // Frame counter wraps at the frame length
      if (lq.fcnt >= frame - 10'h1) begin
        ln.fcnt = 10'h0;
      end else begin
        ln.fcnt = lq.fcnt + 10'h1;
      end
      ln.fs_q = fs_lvl;
      // Serial out: data in enabled slots, else idle mode
      ln.soe_q  = (lq.run && tx_on) || !cf.idle_tri;
      ln.sout_q = lq.run && tx_on && (lq.bitw < wdata)
                  && lq.tx_grp[{lq.widx, bidx}];
      // Schedule the sample of this bit time
      ln.rx_take = lq.run && rx_on && (lq.bitw < wdata);
      ln.rx_widx = lq.widx;
      ln.rx_bit  = bidx;
      // Word accounting at the end of each enabled slot
      if (wend && lq.run && (tx_on || rx_on)) begin
        if (lq.widx == cf.buf_len) begin
          // Group of buffer length plus one words done
          ln.widx      = 2'h0;
          ln.tx_grp    = sq.tx_buf;
          ln.pend      = 1'b1;
          ln.slot_hold = lq.slot;
        end else begin
          ln.widx = lq.widx + 2'h1;
        end
      end
      // Data counters realign every frame
      if (ln.fcnt == off) begin
        ln.bitw  = 5'h0;
        ln.slot  = 5'h0;
        ln.hslot = 4'h0;
        if (!lq.run) begin
          // First word goes in the low half frame
          ln.run    = 1'b1;
          ln.widx   = 2'h0;
          ln.tx_grp = sq.tx_buf;
        end
      end else if (wend) begin
        ln.bitw  = 5'h0;
        ln.slot  = lq.slot + 5'h1;
        ln.hslot = (i2s && lq.hslot == fl_e) ? 4'h0 : lq.hslot + 4'h1;
      end else begin
        ln.bitw = lq.bitw + 5'h1;
      end
    end
  end

  // Link state register
  always_ff @(posedge i_link_bclk or negedge lrst_b) begin
    if (!lrst_b) begin
      lq <= LNK_RST;
    end else begin
      lq <= ln;
    end
  end

  // System next state
  always_comb begin
    sn        = sq;
    // Toggle and sync level cross through two flops each
    sn.tgl_s1 = lq.done_tgl;
    sn.tgl_s2 = sq.tgl_s1;
    sn.tgl_s3 = sq.tgl_s2;
    sn.fs_s1  = lq.fs_q;
    sn.fs_s2  = sq.fs_s1;
    ev        = sq.tgl_s2 ^ sq.tgl_s3;
    // Buffer writes; the link copies them at group start, so
    // software must refill within one group after the flag
    if (i_tx_wr) begin
      sn.tx_buf[{i_tx_idx, 4'h0} +: WORD_W] = i_tx_data;
    end
    // Held group is stable for a whole group, so copy is safe
    if (ev) begin
      sn.rx_buf    = lq.rx_hold;
      sn.slot_stat = lq.slot_hold;
    end
    // Set wins over a clear in the same cycle
    if (i_done_clr) begin
      sn.done = 1'b0;
    end
    if (ev) begin
      sn.done = 1'b1;
    end
  end

  // System state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sq <= SYS_RST;
    end else begin
      sq <= sn;
    end
  end

  // Outputs straight from flops
  assign o_frame_sync_pin = lq.fs_q;
  assign o_serial_out_pin = lq.sout_q;
  assign o_serial_out_oe  = lq.soe_q;
  assign o_rx_words       = sq.rx_buf;
  assign o_done_flag      = sq.done;
  assign o_slot_status    = sq.slot_stat;
  assign o_fs_level       = sq.fs_s2;

endmodule

// *** inc/sapf_pkg.sv ***
// Operation
// - I2S word size 0xF means 16-bit words
// - 24-bit samples use two enabled 16-bit slots
// - Every word leaves MSB first
// - First word at falling frame sync
// - Frame sync level readable by software
// - Default data starts one clock late
// - Justify bit puts MSB at edge
// - Idle output drives zero or floats
// - AC-Link frame is 256 bit times
// - Codec clocks, port drives frame sync
// - AC-Link sync high 16, low 240
// - Data one clock late, sampled falling
// - Mode 10 is AC16, 11 is AC20
// - AC16 keeps 16 bits, zero pads four
// - AC16 slots follow protocol boundaries
// - AC20 forces sixteen packed 16-bit slots
// - AC16 uses only slot enables 12:0
// - Full AC20 frame takes four groups
// - Buffer length sets words per group
// - I2S sync has 50 percent duty
package sapf_pkg;

  // Frame sync mode field codes
  localparam logic [1:0] MODE_MULTI = 2'h0;
  localparam logic [1:0] MODE_I2S   = 2'h1;
  localparam logic [1:0] MODE_AC16  = 2'h2;
  localparam logic [1:0] MODE_AC20  = 2'h3;

  // Word and frame geometry
  localparam int         WORD_W      = 16;
  localparam int         NUM_BUF     = 4;
  localparam logic [9:0] AC_FRAME    = 10'h100;
  localparam logic [9:0] AC_FS_HIGH  = 10'h010;
  localparam logic [4:0] AC_TAG_BITS = 5'h10;
  localparam logic [4:0] AC_SLOT_BITS = 5'h14;
  localparam logic [4:0] AC16_DATA   = 5'h10;
  localparam logic [3:0] AC20_FORCE  = 4'hF;
  localparam logic [15:0] AC16_MASK  = 16'h1FFF;
  localparam logic [15:0] ALL_MASK   = 16'hFFFF;

  // Software configuration bundle
  typedef struct packed {
    logic        en;          // Port enable
    logic [1:0]  fs_mode;     // Frame sync mode field
    logic        justify;     // Justification bit
    logic        idle_tri;    // Idle output mode bit
    logic [3:0]  word_size;   // Word size field, bits minus one
    logic [3:0]  frame_len;   // Frame length field, words minus one
    logic [1:0]  buf_len;     // Buffer length field
    logic [15:0] tx_slot_en;  // Transmit slot enable register
    logic [15:0] rx_slot_en;  // Receive slot enable register
  } sapf_cfg_t;

  // Link clock domain state
  typedef struct packed {
    sapf_cfg_t   cfg_s1;      // Config sync stage one
    sapf_cfg_t   cfg_s2;      // Config sync stage two
    logic [9:0]  fcnt;        // Bit position in frame
    logic [4:0]  bitw;        // Bit position in word
    logic [4:0]  slot;        // Slot in frame
    logic [3:0]  hslot;       // Slot in half frame
    logic [1:0]  widx;        // Word in group
    logic        run;         // Data counters aligned
    logic        pend;        // Group end, last bit pending
    logic [63:0] tx_grp;      // Words being sent
    logic [63:0] rx_grp;      // Words being received
    logic [63:0] rx_hold;     // Finished receive group
    logic [4:0]  slot_hold;   // Slot at group end
    logic        done_tgl;    // Group done event
    logic        rx_take;     // Sample pending
    logic [1:0]  rx_widx;     // Word for pending sample
    logic [3:0]  rx_bit;      // Bit for pending sample
    logic        fs_q;        // Frame sync pin
    logic        sout_q;      // Serial out pin
    logic        soe_q;       // Serial out enable
  } sapf_lnk_t;

  // System clock domain state
  typedef struct packed {
    logic [63:0] tx_buf;      // Transmit buffers zero to three
    logic [63:0] rx_buf;      // Receive buffers zero to three
    logic        done;        // Transfer done flag
    logic [4:0]  slot_stat;   // Slot status field
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_s3;
    logic        fs_s1;
    logic        fs_s2;
  } sapf_sys_t;

  // Values after reset
  localparam sapf_lnk_t LNK_RST = '0;
  localparam sapf_sys_t SYS_RST = '0;

endpackage

// *** tb/sapf_port_assertions.sv ***
`timescale 1ns/1ns
module sapf_port_assertions
  import sapf_pkg::*;
(
  // Clocks and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_link_bclk,
  // Configuration and buffer writes
  input wire sapf_cfg_t   i_cfg,
  input wire logic        i_tx_wr,
  input wire logic [1:0]  i_tx_idx,
  input wire logic [15:0] i_tx_data,
  // Link pins
  input wire logic        o_frame_sync_pin,
  input wire logic        o_serial_out_pin,
  input wire logic        o_serial_out_oe
);
  logic        fs, so, oe, ac, ac16, i2s, grp, fs_q; // Pin and mode views
  logic [9:0]  half, run_q;                          // Half frame, sync level run
  logic [15:0] w0_q;                                 // Copy of buffer zero
  logic        fell_q;                               // Sync fall seen since enable
  assign fs = o_frame_sync_pin;
  assign so = o_serial_out_pin;
  assign oe = o_serial_out_oe;
  assign ac = i_cfg.fs_mode[1];
  assign ac16 = i_cfg.fs_mode == MODE_AC16;
  assign i2s = i_cfg.fs_mode == MODE_I2S;
  // Groups line up with half frames, so every sync edge opens buffer zero
  assign grp = i_cfg.tx_slot_en[0] && i_cfg.buf_len == i_cfg.frame_len[1:0];
  assign half = 10'((i_cfg.frame_len + 1) * (i_cfg.word_size + 1));
  // Length of the sync level that just ended
  always_ff @(posedge i_link_bclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fs_q <= 1'b0;
      run_q <= 10'h000;
      fell_q <= 1'b0;
    end else begin
      fs_q <= fs;
      run_q <= (fs != fs_q) ? 10'h001 : run_q + 10'h001;
      // Justified words only start at a frame boundary, so the first
      // frame after enable carries no data
      fell_q <= i_cfg.en && (fell_q || (fs_q && !fs));
    end
  end
  // Buffer zero is only written while the port is off, so reading it here is safe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) w0_q <= 16'h0000;
    else if (i_tx_wr && i_tx_idx == 2'h0) w0_q <= i_tx_data;
  end
  default clocking @(posedge i_link_bclk); endclocking
  default disable iff (!i_rst_b || !i_cfg.en);
  ac_high_len_a: assert property (ac && $fell(fs) |-> run_q == 10'h010)
    else $error("link sync high time wrong");
  ac_low_len_a: assert property (ac && $fell(fs) |-> ##240 $rose(fs))
    else $error("link sync low time wrong");
  ac_frame_a: assert property (ac && $rose(fs) |-> ##256 $rose(fs))
    else $error("link frame length wrong");
  i2s_half_a: assert property (i2s && $fell(fs) |-> run_q == half)
    else $error("stereo half frame length wrong");
  msb_late_a: assert property (i2s && grp && !i_cfg.justify && $changed(fs)
    |-> ##1 so == w0_q[15] ##1 so == w0_q[14]) else $error("late word start wrong");
  msb_early_a: assert property (i2s && grp && i_cfg.justify && fell_q && $changed(fs)
    |-> so == w0_q[15]) else $error("justified word start wrong");
  tag_drive_a: assert property (ac16 && i_cfg.idle_tri && i_cfg.tx_slot_en[0]
    && !i_cfg.tx_slot_en[12] && $rose(fs) |-> !oe ##1 oe[*8] ##1 oe[*8])
    else $error("tag slot drive window wrong");
  pad_zero_a: assert property (ac16 && i_cfg.tx_slot_en[1] && $rose(fs)
    |-> ##33 !so[*4]) else $error("slot pad bits not zero");
  idle_drive_a: assert property (!i_cfg.idle_tri |-> oe)
    else $error("serial out released in zero mode");
  cover property (ac16 && $rose(fs));
  cover property (i2s && i_cfg.justify && $fell(fs));
  cover property (i_cfg.fs_mode == MODE_AC20 && $fell(fs));
endmodule
bind sapf_port sapf_port_assertions u_chk (.i_clk, .i_rst_b, .i_link_bclk, .i_cfg,
  .i_tx_wr, .i_tx_idx, .i_tx_data, .o_frame_sync_pin, .o_serial_out_pin, .o_serial_out_oe);

// *** tb/sapf_codec_model.sv ***
`timescale 1ns/1ns
module sapf_codec_model (
  // Bit clock made by the codec crystal
  output logic             o_bclk,
  // Link pins
  input  wire logic        i_fs,
  input  wire logic        i_sout,
  output logic             o_sdi,
  // Word repeated every 16 bits from a sync edge, first word caught after a sync edge
  input  wire logic [15:0] i_word,
  output logic [15:0]      o_cap
);
  logic [3:0]  idx;   // Bit being sent, counts down
  logic [15:0] sh;    // Bits caught so far
  logic        fs_l;  // Sync level seen last
  logic        first; // Catching the first word after an edge
  initial {idx, sh, fs_l, first, o_cap} = '0;
  // Free running, unrelated in phase to the system clock
  initial begin
    o_bclk = 1'b0;
    #3;
    forever #6 o_bclk = ~o_bclk;
  end
  // Restart the word on each sync edge; bits change after the rising edge
  always @(posedge o_bclk) begin
    if (idx == 4'h0 && first) o_cap <= sh;
    first <= (i_fs != fs_l) ? 1'b1 : (idx == 4'h0 ? 1'b0 : first);
    idx <= (i_fs != fs_l) ? 4'hF : idx - 4'h1;
    fs_l <= i_fs;
  end
  assign o_sdi = i_word[idx];
  // Receiver samples on the falling edge
  always @(negedge o_bclk) sh <= {sh[14:0], i_sout};
endmodule

// *** tb/sapf_port_test.sv ***
`timescale 1ns/1ns
module sapf_port_test
  import sapf_pkg::*;
();
  logic        clk, rst_b, tx_wr, done_clr;        // Bench drives
  logic [1:0]  tx_idx;
  logic [15:0] tx_data, word, cap;                 // Codec word and caught word
  sapf_cfg_t   cfg;
  logic        bclk, sdi, fs, sout, oe, sdo_w, done, fs_lvl;
  logic [63:0] rx_words;
  logic [4:0]  slot_st;
  int          fail_count, checks;
  assign sdo_w = oe ? sout : 1'bz; // No pull on the serial line
  sapf_port DUT (.i_clk(clk), .i_rst_b(rst_b), .i_link_bclk(bclk), .i_cfg(cfg),
    .i_tx_wr(tx_wr), .i_tx_idx(tx_idx), .i_tx_data(tx_data), .i_done_clr(done_clr),
    .i_serial_in_pin(sdi), .o_frame_sync_pin(fs), .o_serial_out_pin(sout),
    .o_serial_out_oe(oe), .o_rx_words(rx_words), .o_done_flag(done),
    .o_slot_status(slot_st), .o_fs_level(fs_lvl));
  sapf_codec_model u_codec (.o_bclk(bclk), .i_fs(fs), .i_sout(sdo_w), .o_sdi(sdi),
    .i_word(word), .o_cap(cap));
  always #10 clk = ~clk;
  // Compare and count
  task automatic chk(input string what, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Wait for the done flag under a bound, note the time, then clear it
  task automatic wait_done(output time t);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("done flag", done, 1'b1);
    t = $time;
    done_clr = 1'b1;
    @(negedge clk);
    done_clr = 1'b0;
  endtask
  // One configuration: load buffers while off, enable, wait three groups, time the last
  task automatic run_case(input logic [1:0] md, input logic [3:0] wsz, fl,
      input logic jst, idl, input logic [1:0] bl, input logic [15:0] tsl, rsl,
      input int g, nrx);
    time t0, t1, t2;
    logic [4:0] s1;
    logic [15:0] d;
    int dlt;
    cfg.en = 1'b0;
    @(negedge clk);
    cfg = '{en: 1'b0, fs_mode: md, justify: jst, idle_tri: idl, word_size: wsz,
            frame_len: fl, buf_len: bl, tx_slot_en: tsl, rx_slot_en: rsl};
    d = 16'($urandom);
    word = 16'($urandom);
    for (int i = 0; i < 4; i++) begin
      tx_wr = 1'b1;
      tx_idx = 2'(i);
      tx_data = (i > 0 && md == MODE_I2S) ? {d[7:0], 8'h00} : d;
      @(negedge clk);
    end
    tx_wr = 1'b0;
    repeat (4) @(negedge clk);
    // Buffers are filled before the port starts, as a DMA master would
    cfg.en = 1'b1;
    wait_done(t0);
    wait_done(t1);
    s1 = slot_st;
    wait_done(t2);
    // Sync of the flag adds up to one system clock of jitter
    dlt = int'((t2 - t1) / 12) - g;
    chk("group len", dlt >= -3 && dlt <= 3, 1'b1);
    for (int i = 0; i < nrx; i++) chk("rx word", rx_words[16*i +: 16], word);
    chk("tx word", cap, jst ? {d[14:0], d[15]} : d);
    if (md == MODE_AC20) chk("slot step", 4'(slot_st - s1), 4'h4);
    @(fs);
    repeat (6) @(negedge clk);
    chk("fs level", fs_lvl, fs);
    $display("case mode %0d done", md);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    tx_wr = 1'b0;
    tx_idx = 2'h0;
    tx_data = 16'h0000;
    done_clr = 1'b0;
    word = 16'h0000;
    cfg = '0;
    fail_count = 0;
    checks = 0;
    void'($urandom(53));
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    run_case(MODE_I2S, 4'hF, 4'h0, 1'b0, 1'b0, 2'h0, 16'h0001, 16'h0001, 16, 1);
    run_case(MODE_I2S, 4'hF, 4'h1, 1'b0, 1'b0, 2'h1, 16'h0003, 16'h0003, 32, 2);
    run_case(MODE_I2S, 4'hF, 4'h0, 1'b1, 1'b1, 2'h0, 16'h0001, 16'h0001, 16, 0);
    run_case(MODE_AC16, 4'h0, 4'h0, 1'b0, 1'b1, 2'h1, 16'h8003, 16'h8001, 256, 1);
    run_case(MODE_AC20, 4'h0, 4'h0, 1'b0, 1'b0, 2'h3, 16'hFFFF, 16'hFFFF, 64, 4);
    summarize();
  end
  // Five cases take under 20 us each
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
endmodule
